// File: hdl/prioritized_interrupt_controller.v
// Prioritized maskable interrupt acceptance logic with external pin, key and trap inputs
// Functional notes
// - Accept: request 1, mask 0, IE 1, level <= service
// - Service level 00..11 admits levels 0..all
// - Request flag reads 1 while request pending
// - Mask 0 permits, 1 blocks, request kept
// - Level select 00 highest to 11 lowest
// - Edge pair: off, falling, rising, both edges
// - Bit n of edge registers controls pin n
// - Redirection bits 0, 1, 4, 5 pick alternate pin when 1
// - Key mode bit 1 enables that key input
// - All key inputs share one request flag
// - Higher priority level wins among simultaneous
// - Same level: lowest source index wins
// - Stack status word first, then program counter
// - Software trap taken even when IE is 0
// - Trap bypasses arbitration and service level
// - Trap has one single handler entry
// - No pin-driven non-maskable interrupt exists
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "intc_defs.vh"
module prioritized_interrupt_controller #(
	parameter NSRC = 16,
	parameter NPIN = 12,
	parameter NKEY = 8
) (
	input wire clk,
	input wire rstn,
	input wire [3:0] addr,
	input wire [15:0] wdata,
	input wire wr,
	input wire rd,
	input wire [15:0] rdata_dummy_unused_n,
	output reg [15:0] rdata,
	input wire [NPIN-1:0] pin_default,
	input wire [NPIN-1:0] pin_alternate,
	input wire [NKEY-1:0] key_in,
	input wire [NSRC-1:0] periph_req,
	input wire trap_req,
	input wire return_req,
	input wire [7:0] restore_psw,
	input wire stack_ack,
	output reg int_take,
	output reg [4:0] int_source,
	output reg stack_push,
	output reg stack_sel_pc,
	output reg [7:0] stacked_psw,
	output reg [7:0] psw_out
);
	// Register state
	reg [NSRC-1:0] req_reg; // Request flags
	reg [NSRC-1:0] mask_reg; // Mask flags
	reg [NSRC-1:0] lvl_hi_reg; // Level high bits
	reg [NSRC-1:0] lvl_lo_reg; // Level low bits
	reg [NPIN-1:0] rise_reg; // Rising edge enables
	reg [NPIN-1:0] fall_reg; // Falling edge enables
	reg [7:0] redir_reg; // Redirection control
	reg [NKEY-1:0] keym_reg; // Key detect enables
	reg [7:0] psw_reg; // Processor status word
	reg [4:0] last_reg; // Last accepted source
	// Pin synchronisers and previous samples
	reg [NPIN-1:0] pd_s1, pd_s2, pa_s1, pa_s2, pin_prev;
	reg [NKEY-1:0] k_s1, k_s2, k_prev;
	// Sequencer
	localparam S_IDLE = 2'd0;
	localparam S_PSW = 2'd1;
	localparam S_PC = 2'd2;
	reg [1:0] st_reg;
	// Per-pin redirection group select
	function redir_sel;
		input [3:0] n;
		input [7:0] r;
		begin
			case (n)
				4'd1, 4'd2, 4'd3, 4'd4, 4'd8, 4'd9: redir_sel = r[0];
				4'd10, 4'd11: redir_sel = r[1];
				4'd5: redir_sel = r[4];
				4'd6, 4'd7: redir_sel = r[5];
				default: redir_sel = 1'b0;
			endcase
		end
	endfunction
	// Routed pin levels and edge events
	reg [NPIN-1:0] pin_now;
	reg [NPIN-1:0] pin_evt;
	integer i;
	always @* begin
		for (i = 0; i < NPIN; i = i + 1) begin
			pin_now[i] = redir_sel(i[3:0], redir_reg) ? pa_s2[i] : pd_s2[i];
			pin_evt[i] = (rise_reg[i] & pin_now[i] & ~pin_prev[i])
				| (fall_reg[i] & ~pin_now[i] & pin_prev[i]);
		end
	end
	// Key event: any enabled falling key input
	wire key_evt = |(keym_reg & ~k_s2 & k_prev);
	// Arbitration: best level, lowest index on ties
	wire [1:0] isp = {psw_reg[`F_ISP_HI], psw_reg[`F_ISP_LO]};
	reg found;
	reg [4:0] win;
	reg [1:0] win_lvl;
	reg [1:0] l;
	always @* begin
		found = 1'b0;
		win = 5'h00;
		win_lvl = 2'h3;
		l = 2'h0;
		for (i = 0; i < NSRC; i = i + 1) begin
			l = {lvl_hi_reg[i], lvl_lo_reg[i]};
			if (req_reg[i] && !mask_reg[i] && (l <= isp)
				&& (!found || l < win_lvl)) begin
				found = 1'b1;
				win = i[4:0];
				win_lvl = l;
			end
		end
	end
	// Acceptance only from maskable sources; no pin bypasses it
	wire accept = (st_reg == S_IDLE) && psw_reg[`F_IE] && found && !trap_req;
	wire trap_go = (st_reg == S_IDLE) && trap_req;
	// Synchronisers
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pd_s1 <= {NPIN{1'b0}};
			pd_s2 <= {NPIN{1'b0}};
			pa_s1 <= {NPIN{1'b0}};
			pa_s2 <= {NPIN{1'b0}};
			pin_prev <= {NPIN{1'b0}};
			k_s1 <= {NKEY{1'b1}};
			k_s2 <= {NKEY{1'b1}};
			k_prev <= {NKEY{1'b1}};
		end else begin
			pd_s1 <= pin_default;
			pd_s2 <= pd_s1;
			pa_s1 <= pin_alternate;
			pa_s2 <= pa_s1;
			pin_prev <= pin_now;
			k_s1 <= key_in;
			k_s2 <= k_s1;
			k_prev <= k_s2;
		end
	end
	// Request flags: set beats clear
	reg [NSRC-1:0] set_v;
	reg [NSRC-1:0] clr_v;
	always @* begin
		set_v = periph_req;
		set_v[NPIN-1:0] = set_v[NPIN-1:0] | pin_evt;
		set_v[`KEY_SRC] = set_v[`KEY_SRC] | key_evt;
		clr_v = {NSRC{1'b0}};
		if (wr && addr == `A_REQ_FLAGS)
			clr_v = ~wdata[NSRC-1:0];
		if (accept)
			clr_v[win[3:0]] = 1'b1;
	end
	// Register writes, flags and status word
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			req_reg <= {NSRC{1'b0}};
			mask_reg <= `RST_MASK;
			{lvl_hi_reg, lvl_lo_reg} <= {`RST_LEVEL, `RST_LEVEL};
			rise_reg <= {NPIN{1'b0}};
			fall_reg <= {NPIN{1'b0}};
			redir_reg <= `RST_REDIRECT;
			keym_reg <= {NKEY{1'b0}};
			psw_reg <= `RST_PSW;
			last_reg <= 5'h00;
		end else begin
			req_reg <= (req_reg & ~clr_v) | set_v;
			if (wr) begin
				case (addr)
					`A_MASK_FLAGS: mask_reg <= wdata[NSRC-1:0];
					`A_LEVEL_HIGH: lvl_hi_reg <= wdata[NSRC-1:0];
					`A_LEVEL_LOW: lvl_lo_reg <= wdata[NSRC-1:0];
					`A_RISE_EN0: rise_reg[7:0] <= wdata[7:0];
					`A_RISE_EN1: rise_reg[NPIN-1:8] <= wdata[NPIN-9:0];
					`A_FALL_EN0: fall_reg[7:0] <= wdata[7:0];
					`A_FALL_EN1: fall_reg[NPIN-1:8] <= wdata[NPIN-9:0];
					`A_REDIRECT: redir_reg <= wdata[7:0];
					`A_KEY_MODE: keym_reg <= wdata[NKEY-1:0];
					`A_STATUS: psw_reg <= wdata[7:0];
					default: ;
				endcase
			end
			if (accept) begin
				psw_reg[`F_IE] <= 1'b0;
				{psw_reg[`F_ISP_HI], psw_reg[`F_ISP_LO]} <= (win_lvl == 2'h0) ? 2'h0 : win_lvl - 2'h1;
				last_reg <= win;
			end else if (trap_go) begin
				psw_reg[`F_IE] <= 1'b0;
				last_reg <= `TRAP_SRC;
			end else if (return_req) begin
				psw_reg <= restore_psw;
			end
		end
	end
	// Stacking sequence and core outputs
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= S_IDLE;
			int_take <= 1'b0;
			int_source <= 5'h00;
			stack_push <= 1'b0;
			stack_sel_pc <= 1'b0;
			stacked_psw <= 8'h00;
		end else begin
			int_take <= 1'b0;
			case (st_reg)
				S_IDLE: begin
					if (accept || trap_go) begin
						st_reg <= S_PSW;
						int_take <= 1'b1;
						int_source <= trap_go ? `TRAP_SRC : win;
						stack_push <= 1'b1;
						stack_sel_pc <= 1'b0;
						stacked_psw <= psw_reg;
					end
				end
				S_PSW: begin
					if (stack_ack) begin
						st_reg <= S_PC;
						stack_sel_pc <= 1'b1;
					end
				end
				S_PC: begin
					if (stack_ack) begin
						st_reg <= S_IDLE;
						stack_push <= 1'b0;
						stack_sel_pc <= 1'b0;
					end
				end
				default: st_reg <= S_IDLE;
			endcase
		end
	end
	// Status word mirror
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			psw_out <= `RST_PSW;
		else
			psw_out <= psw_reg;
	end
	// Read data one cycle after the strobe
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 16'h0000;
		end else if (rd) begin
			case (addr)
				`A_REQ_FLAGS: rdata <= req_reg;
				`A_MASK_FLAGS: rdata <= mask_reg;
				`A_LEVEL_HIGH: rdata <= lvl_hi_reg;
				`A_LEVEL_LOW: rdata <= lvl_lo_reg;
				`A_RISE_EN0: rdata <= {8'h00, rise_reg[7:0]};
				`A_RISE_EN1: rdata <= {12'h000, rise_reg[NPIN-1:8]};
				`A_FALL_EN0: rdata <= {8'h00, fall_reg[7:0]};
				`A_FALL_EN1: rdata <= {12'h000, fall_reg[NPIN-1:8]};
				`A_REDIRECT: rdata <= {8'h00, redir_reg};
				`A_KEY_MODE: rdata <= {8'h00, keym_reg};
				`A_STATUS: rdata <= {8'h00, psw_reg};
				`A_ACCEPTED: rdata <= {11'h000, last_reg};
				default: rdata <= 16'h0000;
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end
endmodule // prioritized_interrupt_controller

// File: inc/intc_defs.vh
// Register offsets, field positions, reset values and constants of the interrupt controller
`ifndef INTC_DEFS_VH
`define INTC_DEFS_VH
`define A_REQ_FLAGS 4'h0
`define A_MASK_FLAGS 4'h1
`define A_LEVEL_HIGH 4'h2
`define A_LEVEL_LOW 4'h3
`define A_RISE_EN0 4'h4
`define A_RISE_EN1 4'h5
`define A_FALL_EN0 4'h6
`define A_FALL_EN1 4'h7
`define A_REDIRECT 4'h8
`define A_KEY_MODE 4'h9
`define A_STATUS 4'hA
`define A_ACCEPTED 4'hB
`define F_IE 7
`define F_ISP_HI 2
`define F_ISP_LO 1
`define RST_MASK 16'hFFFF
`define RST_LEVEL 16'hFFFF
`define RST_PSW 8'h06
`define RST_REDIRECT 8'h00
`define KEY_SRC 12
`define TRAP_SRC 5'h1F
`define IDLE_LEVEL 2'h3
`endif

// File: bench/intc_chk_asserts.sv
// Checker of acceptance, trap and stacking at the core side
`timescale 1ns/10ps
module intc_chk (
	input wire clk,
	input wire rstn,
	input wire trap_req,
	input wire stack_ack,
	input wire int_take,
	input wire [4:0] int_source,
	input wire stack_push,
	input wire stack_sel_pc,
	input wire [7:0] stacked_psw,
	input wire [7:0] psw_out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Acceptance pulse, stacking order and release
	take_pulse_a: assert property (int_take |-> stack_push ##1 !int_take)
		else $error("take pulse");
	psw_first_a: assert property ($rose(stack_push) |-> !stack_sel_pc)
		else $error("status word not first");
	pc_after_a: assert property (stack_push && !stack_sel_pc && stack_ack |=> stack_push && stack_sel_pc)
		else $error("pc word missing");
	push_end_a: assert property (stack_sel_pc && stack_ack |=> !stack_push)
		else $error("stacking not ended");
	// Status word gating and trap path
	ie_was_set_a: assert property (int_take && int_source != 5'h1F |-> stacked_psw[7])
		else $error("accepted with enable low");
	ie_clear_a: assert property (int_take && int_source != 5'h1F |-> ##[0:2] !psw_out[7])
		else $error("enable not cleared");
	one_vector_a: assert property (int_take |-> int_source < 5'h10 || int_source == 5'h1F)
		else $error("bad source");
	trap_go_a: assert property (trap_req && !stack_push && !int_take |-> ##[1:3] int_take)
		else $error("trap not taken");
	cover property (int_take && int_source == 5'h1F);
	cover property (int_take && int_source == 5'h0C);
	cover property (stack_sel_pc && stack_ack);
endmodule // intc_chk
bind prioritized_interrupt_controller intc_chk intc_chk_i (.clk, .rstn, .trap_req, .stack_ack,
	.int_take, .int_source, .stack_push, .stack_sel_pc, .stacked_psw, .psw_out);

// File: bench/core_model.sv
// Core side model that takes stacked words promptly or slowly
`timescale 1ns/10ps
module core_model (
	input wire clk,
	input wire rstn,
	input wire slow,
	input wire stack_push,
	output reg stack_ack
);
	reg [1:0] wait_reg; // Cycles spent on the current word
	// One word at a time: status word, then program counter
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stack_ack <= 1'b0;
			wait_reg <= 2'h0;
		end else begin
			stack_ack <= 1'b0;
			if (stack_push && !stack_ack) begin
				if (!slow || wait_reg == 2'h3) begin
					stack_ack <= 1'b1;
					wait_reg <= 2'h0;
				end else begin
					wait_reg <= wait_reg + 2'h1;
				end
			end
		end
	end
endmodule // core_model

// File: bench/tb.sv
// Testbench of the interrupt controller with queued expectations
`timescale 1ns/10ps
`include "intc_defs.vh"
module tb;
	reg clk = 1'b0;
	reg rstn = 1'b0;
	reg [3:0] addr = 4'h0;
	reg [15:0] wdata = 16'h0000;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg rd_d = 1'b0;
	reg [11:0] pin_default = 12'h000;
	reg [11:0] pin_alternate = 12'h000;
	reg [7:0] key_in = 8'hFF;
	reg [15:0] periph_req = 16'h0000;
	reg trap_req = 1'b0;
	reg return_req = 1'b0;
	reg [7:0] restore_psw = 8'h00;
	reg slow = 1'b0;
	wire [15:0] rdata;
	wire stack_ack, int_take, stack_push, stack_sel_pc;
	wire [4:0] int_source;
	wire [7:0] stacked_psw, psw_out;
	reg [15:0] exp_q[$]; // Expected read data
	reg [4:0] src_q[$]; // Expected accepted sources
	integer err_total = 0;
	integer checked = 0;
	integer i, k;
	always #10 clk = ~clk;
	prioritized_interrupt_controller prioritized_interrupt_controller_i (.clk, .rstn, .addr,
		.wdata, .wr, .rd, .rdata_dummy_unused_n(16'h0000), .rdata, .pin_default,
		.pin_alternate, .key_in, .periph_req, .trap_req, .return_req, .restore_psw,
		.stack_ack, .int_take, .int_source, .stack_push, .stack_sel_pc, .stacked_psw, .psw_out);
	core_model core_model_i (.clk, .rstn, .slow, .stack_push, .stack_ack);
	task chk(input string nm, input [15:0] seen, input [15:0] want);
		begin
			checked = checked + 1;
			if (seen !== want) begin
				err_total = err_total + 1;
				$display("ERROR %s expected %h seen %h", nm, want, seen);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", checked, err_total);
			if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
			else $display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// One bus cycle; a read notes its expected data
	task bus(input w, input [3:0] a, input [15:0] d);
		begin
			addr <= a;
			wdata <= d;
			wr <= w;
			rd <= !w;
			if (!w) exp_q.push_back(d);
			@(posedge clk);
			wr <= 1'b0;
			rd <= 1'b0;
			@(posedge clk);
		end
	endtask
	// Wait until noted acceptances are seen and stacked
	task drain;
		begin
			for (i = 0; i < 80 && (src_q.size() != 0 || stack_push); i = i + 1) @(posedge clk);
			if (i == 80) begin
				chk("drain", 16'h0001, 16'h0000);
				wrap_up;
			end
		end
	endtask
	// Return from handler with a given status word
	task ret(input [7:0] p);
		begin
			restore_psw <= p;
			return_req <= 1'b1;
			@(posedge clk);
			return_req <= 1'b0;
			@(posedge clk);
		end
	endtask
	// Compare results with the oldest notes
	always @(posedge clk) begin
		rd_d <= rd;
		if (rd_d) chk("rdata", rdata, exp_q.pop_front());
		if (int_take) begin
			if (int_source != `TRAP_SRC) chk("stacked enable", stacked_psw[7], 1'b1);
			if (src_q.size() == 0) chk("unexpected take", 16'h0001, 16'h0000);
			else chk("source", int_source, src_q.pop_front());
		end
	end
	initial begin
		k = $urandom(32'h3DA9);
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		bus(0, 4'h1, `RST_MASK);
		bus(0, 4'h2, `RST_LEVEL);
		bus(0, 4'hA, {8'h00, `RST_PSW});
		bus(0, 4'h8, {8'h00, `RST_REDIRECT});
		bus(0, 4'hC, 16'h0000);
		$display("reset values done");
		bus(1, 4'h1, 16'h0FF7);
		bus(1, 4'h2, 16'h3FFF);
		bus(1, 4'h3, 16'hDFFF);
		periph_req <= 16'hE000;
		@(posedge clk);
		periph_req <= 16'h0000;
		src_q.push_back(5'h0E);
		ret(8'h86);
		drain;
		src_q.push_back(5'h0F);
		ret(8'h86);
		drain;
		ret(8'h82);
		repeat (8) @(posedge clk);
		bus(0, 4'h0, 16'h2000);
		src_q.push_back(5'h0D);
		ret(8'h84);
		drain;
		$display("priority and service level done");
		slow <= 1'b1;
		bus(1, 4'h4, 16'h0008);
		bus(1, 4'h8, 16'h0001);
		pin_default <= 12'h008;
		repeat (6) @(posedge clk);
		src_q.push_back(5'h03);
		pin_alternate <= 12'h008;
		repeat (6) @(posedge clk);
		ret(8'h86);
		drain;
		$display("pin edge done");
		k = $urandom % 8;
		bus(1, 4'h9, 16'h0001 << k);
		key_in <= 8'h00;
		src_q.push_back(`KEY_SRC);
		ret(8'h86);
		drain;
		$display("key input done");
		trap_req <= 1'b1;
		src_q.push_back(`TRAP_SRC);
		for (k = 0; k < 10 && !int_take; k = k + 1) @(posedge clk);
		trap_req <= 1'b0;
		drain;
		$display("trap done");
		// Pin 0 at level 0 still taken with service level 00
		bus(1, 4'h1, 16'h0FF6);
		bus(1, 4'h2, 16'h3FFE);
		bus(1, 4'h3, 16'hDFFE);
		bus(1, 4'h6, 16'h0001);
		pin_default <= 12'h009;
		repeat (4) @(posedge clk);
		pin_default <= 12'h008;
		src_q.push_back(5'h00);
		ret(8'h80);
		drain;
		$display("level 0 pin done");
		wrap_up;
	end
endmodule // tb
